// ===== wwdt_pkg.sv
// constants and register map of the windowed watchdog timer
// assumes a 32-bit apb master and tick strobes synchronous to ref_clk
// How it works
// - in window mode a service write before the last quarter of the period resets the system.
// - in the open window the arm byte may repeat; the fire byte after it restarts the period.
// - with stop_in_debug set, watchdog and periodic tick counters halt in background debug.
// - control_write_mask is write-only and a masked write keeps window, rate and the once flag.
// - a nonzero timeout_rate_select enables the counter and starts a new period; zero disables.
// - counter expiry asserts system reset unless software services the counter in time.
// - enabled, in debug, stop_in_debug clear and special mode forces longest normal period.
// - rate codes 1..7 give 2^14, 2^16, 2^18, 2^20, 2^22, 2^23 and 2^24 watchdog clocks.
// - watchdog_clock_source_select picks the oscillator tick, else the internal reference tick.
// - the rate table applies while watchdog_clock_group_select is zero, its reset value.
// - window_mode_enable 0 gives normal operation, 1 gives windowed operation.

package wwdt_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int          WWDT_AW       = 8;
    localparam logic [7:0]  WWDT_CTRL_OFS = 8'h00;
    localparam logic [7:0]  WWDT_SVC_OFS  = 8'h04;
    localparam logic [7:0]  WWDT_STAT_OFS = 8'h08;
    localparam logic [7:0]  WWDT_CFG_OFS  = 8'h0c;

    // ****************************************
    // fields
    // ****************************************
    localparam int          WWDT_WIN_BIT  = 7;
    localparam int          WWDT_STOP_BIT = 6;
    localparam int          WWDT_MASK_BIT = 5;
    localparam int          WWDT_RATE_LSB = 0;
    localparam int          WWDT_RATE_W   = 3;
    localparam int          WWDT_SRC_BIT  = 0;
    localparam int          WWDT_GRP_BIT  = 1;
    localparam int          WWDT_CNT_W    = 24;

    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic [2:0]  WWDT_RATE_RST = 3'h0;
    localparam logic [2:0]  WWDT_RATE_MAX = 3'h7;
    localparam logic        WWDT_BIT_RST  = 1'b0;
    localparam logic [7:0]  WWDT_SVC_ARM  = 8'h55;
    localparam logic [7:0]  WWDT_SVC_FIRE = 8'haa;

    // ****************************************
    // timing: log2 of period per rate code
    // ****************************************
    localparam logic [4:0]  WWDT_SHIFT [0:7] = '{5'h00, 5'h0e, 5'h10, 5'h12,
                                                 5'h14, 5'h16, 5'h17, 5'h18};
    localparam logic [4:0]  WWDT_QTR_SH = 5'h02;

endpackage

// ===== wwdt_top.sv
// windowed watchdog timer with apb register access
// assumes tick strobes and debug/mode levels synchronous to ref_clk
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps

module wwdt_top (
    input  wire logic                         ref_clk,
    input  wire logic                         arst_n,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [wwdt_pkg::WWDT_AW-1:0] paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         irc_tick,
    input  wire logic                         osc_tick,
    input  wire logic                         debug_active,
    input  wire logic                         special_mode,
    output logic                              tick_halt,
    output logic                              sys_reset
);
    import wwdt_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    // ****************************************
    // apb decode
    // ****************************************
    logic setup;
    logic wr;
    logic mapped;
    logic ctrl_wr;
    logic svc_wr;
    logic cfg_wr;

    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite;
    assign mapped  = (paddr == WWDT_CTRL_OFS) || (paddr == WWDT_SVC_OFS) ||
                     (paddr == WWDT_STAT_OFS) || (paddr == WWDT_CFG_OFS);
    assign ctrl_wr = wr && (paddr == WWDT_CTRL_OFS);
    assign svc_wr  = wr && (paddr == WWDT_SVC_OFS);
    assign cfg_wr  = wr && (paddr == WWDT_CFG_OFS);

    // ****************************************
    // control and configuration registers
    // ****************************************
    logic                   win;
    logic                   stop;
    logic [WWDT_RATE_W-1:0] rate;
    logic                   once;
    logic                   src;
    logic                   grp;
    logic [WWDT_RATE_W-1:0] wr_rate;
    logic                   wr_masked;

    assign wr_rate   = pwdata[WWDT_RATE_LSB +: WWDT_RATE_W];
    assign wr_masked = pwdata[WWDT_MASK_BIT];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop <= WWDT_BIT_RST;
        end else if (ctrl_wr) begin
            stop <= pwdata[WWDT_STOP_BIT];
        end
    end

    // window and rate take one write; a masked write leaves them alone
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            win  <= WWDT_BIT_RST;
            rate <= WWDT_RATE_RST;
            once <= WWDT_BIT_RST;
        end else if (ctrl_wr && !wr_masked && !once) begin
            win  <= pwdata[WWDT_WIN_BIT];
            rate <= wr_rate;
            once <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src <= WWDT_BIT_RST;
            grp <= WWDT_BIT_RST;
        end else if (cfg_wr) begin
            src <= pwdata[WWDT_SRC_BIT];
            grp <= pwdata[WWDT_GRP_BIT];
        end
    end

    // ****************************************
    // effective mode
    // ****************************************
    logic                   enabled;
    logic                   forced;
    logic                   halt;
    logic                   tick;
    logic [WWDT_RATE_W-1:0] eff_rate;
    logic                   eff_win;
    logic [4:0]             sh;
    logic [WWDT_CNT_W:0]    span;
    logic [WWDT_CNT_W-1:0]  last;
    logic [WWDT_CNT_W-1:0]  win_start;
    logic [WWDT_CNT_W-1:0]  count;

    assign enabled  = (rate != WWDT_RATE_RST);
    assign forced   = enabled & debug_active & ~stop & special_mode;
    assign eff_rate = (forced | grp) ? WWDT_RATE_MAX : rate;
    assign eff_win  = win & ~forced;
    assign halt     = stop & debug_active;
    assign tick     = src ? osc_tick : irc_tick;

    always_comb begin
        sh        = WWDT_SHIFT[eff_rate];
        span      = (WWDT_CNT_W+1)'(1) << sh;
        last      = WWDT_CNT_W'(span - (WWDT_CNT_W+1)'(1));
        win_start = WWDT_CNT_W'(3) << (sh - WWDT_QTR_SH);
    end

    // ****************************************
    // service sequence
    // ****************************************
    logic       in_window;
    logic [7:0] svc_val;
    logic       start;
    logic       armed;
    logic       fire;
    logic       bad;
    logic       expire;

    assign in_window = (count >= win_start);
    assign svc_val   = pwdata[7:0];
    assign start     = ctrl_wr && !wr_masked && !once && (wr_rate != WWDT_RATE_RST);
    assign bad       = svc_wr && enabled &&
                       (((svc_val != WWDT_SVC_ARM) && (svc_val != WWDT_SVC_FIRE)) ||
                        (eff_win && !in_window));
    assign fire      = svc_wr && enabled && !bad && armed &&
                       (svc_val == WWDT_SVC_FIRE);
    assign expire    = enabled && tick && !halt && (count == last);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (start || fire) begin
            armed <= 1'b0;
        end else if (svc_wr && enabled && !bad && (svc_val == WWDT_SVC_ARM)) begin
            armed <= 1'b1;
        end
    end

    // ****************************************
    // counter and reset request
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (start || fire || expire) begin
            count <= '0;
        end else if (enabled && tick && !halt) begin
            count <= count + WWDT_CNT_W'(1);
        end
    end

    // held until the system reset comes back through arst_n
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_reset <= 1'b0;
        end else if (expire || bad) begin
            sys_reset <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_halt <= 1'b0;
        end else begin
            tick_halt <= halt;
        end
    end

    // ****************************************
    // apb answer
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
        end
    end

    // data and error are prepared in the setup cycle, so no wait states
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= !mapped;
            unique case (paddr)
                WWDT_CTRL_OFS: prdata <= {24'h000000, win, stop, 3'h0, rate};
                WWDT_STAT_OFS: prdata <= {6'h00, once, enabled, count};
                WWDT_CFG_OFS:  prdata <= {30'h00000000, grp, src};
                default:       prdata <= '0;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_arm;
        svc_wr && enabled && !bad && (svc_val == WWDT_SVC_ARM);
    endsequence

    sequence s_fire;
        svc_wr && armed && enabled && (svc_val == WWDT_SVC_FIRE) &&
        (!eff_win || in_window);
    endsequence

    property p_early;
        @(posedge ref_clk) disable iff (!rst_n)
        svc_wr && enabled && eff_win && (count < win_start) |=> sys_reset;
    endproperty
    a_early: assert property (p_early) else $error("early service missed");

    property p_open;
        @(posedge ref_clk) disable iff (!rst_n)
        svc_wr && enabled && eff_win && in_window && !expire && !sys_reset &&
        ((svc_val == WWDT_SVC_ARM) || (svc_val == WWDT_SVC_FIRE)) |=> !sys_reset;
    endproperty
    a_open: assert property (p_open) else $error("service in window reset");

    property p_restart;
        @(posedge ref_clk) disable iff (!rst_n)
        s_arm ##1 (!svc_wr && !ctrl_wr) [*2] ##1 s_fire |=> (count == '0) && !armed;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

    property p_halt;
        @(posedge ref_clk) disable iff (!rst_n)
        halt && !wr |=> $stable(count) && tick_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("counter ran in debug");

    property p_mask;
        @(posedge ref_clk) disable iff (!rst_n)
        ctrl_wr && wr_masked |=> $stable(rate) && $stable(win) && $stable(once);
    endproperty
    a_mask: assert property (p_mask) else $error("masked write changed mode");

    property p_start;
        @(posedge ref_clk) disable iff (!rst_n)
        ctrl_wr && !wr_masked && !once && (wr_rate != 3'h0)
        |=> enabled && (count == '0) && once;
    endproperty
    a_start: assert property (p_start) else $error("no start");

    property p_expire;
        @(posedge ref_clk) disable iff (!rst_n)
        enabled && tick && !halt && (count == last) |=> sys_reset && (count == '0);
    endproperty
    a_expire: assert property (p_expire) else $error("no expiry reset");

    property p_forced;
        @(posedge ref_clk) disable iff (!rst_n)
        enabled && debug_active && !stop && special_mode
        |-> (last == 24'hffffff) && !eff_win;
    endproperty
    a_forced: assert property (p_forced) else $error("not forced");

    property p_rate;
        @(posedge ref_clk) disable iff (!rst_n)
        (rate == 3'h1) && !forced && !grp |-> (last == 24'h003fff) &&
        (win_start == 24'h003000);
    endproperty
    a_rate: assert property (p_rate) else $error("bad period");

    property p_src;
        @(posedge ref_clk) disable iff (!rst_n)
        enabled && !halt && src && !irc_tick && osc_tick && (count != last) &&
        !start && !fire |=> (count == $past(count) + 24'h000001);
    endproperty
    a_src: assert property (p_src) else $error("wrong clock");

    property p_badval;
        @(posedge ref_clk) disable iff (!rst_n)
        svc_wr && enabled && (svc_val != 8'h55) && (svc_val != 8'haa) |=> sys_reset;
    endproperty
    a_badval: assert property (p_badval) else $error("bad value accepted");

endmodule

// ===== windowed_watchdog_timer_tb.sv
// self-checking testbench for the windowed watchdog timer
// assumes ticks may pulse every cycle; bus waits end only by the run watchdog
`timescale 1ns/1ps

module windowed_watchdog_timer_tb;
    import wwdt_pkg::*;

    // ****************************************
    // signals
    // ****************************************
    logic        ref_clk, arst_n, psel, penable, pwrite;
    logic [7:0]  paddr, v;
    logic [31:0] pwdata, prdata, rd, s1, e;
    logic        pready, pslverr, err, irc_tick, osc_tick;
    logic        debug_active, special_mode, tick_halt, sys_reset;
    integer      n_fail, check_count, seed, n_osc, r;

    wwdt_top u_wwdt_top (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .irc_tick     (irc_tick),
        .osc_tick     (osc_tick),
        .debug_active (debug_active),
        .special_mode (special_mode),
        .tick_halt    (tick_halt),
        .sys_reset    (sys_reset)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ****************************************
    // tasks
    // ****************************************
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task wt(input integer n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task do_reset;
        arst_n       <= 1'b0;
        debug_active <= 1'b0;
        special_mode <= 1'b0;
        irc_tick     <= 1'b1;
        osc_tick     <= 1'b0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask

    // ****************************************
    // watchdog of the run
    // ****************************************
    initial begin
        #400000;
        n_fail++;
        stop_test;
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        seed = 27242;
        n_fail = 0;
        check_count = 0;
        arst_n = 1'b0;
        {psel, penable, pwrite, irc_tick, osc_tick, debug_active, special_mode} = 7'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        do_reset;
        rdc(WWDT_CFG_OFS, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        // every rate code, masked write first
        irc_tick <= 1'b0;
        for (r = 0; r < 8; r++) begin
            do_reset;
            irc_tick <= 1'b0;
            wr(WWDT_CTRL_OFS, 32'h25);
            rdc(WWDT_CTRL_OFS, 32'h0);
            rdc(WWDT_STAT_OFS, 32'h0);
            e = 32'(r) + 32'((r % 2) * 128);
            wr(WWDT_CTRL_OFS, e);
            rdc(WWDT_CTRL_OFS, e);
            rdc(WWDT_STAT_OFS, {6'h0, 1'b1, r != 0, 24'h0});
        end
        // restart by arm and fire bytes, then expiry
        do_reset;
        wr(WWDT_CTRL_OFS, 32'h1);
        wt(10000);
        wr(WWDT_SVC_OFS, 32'h55);
        wr(WWDT_SVC_OFS, 32'h55);
        wr(WWDT_SVC_OFS, 32'haa);
        wt(16384 - 30);
        chk(sys_reset, 1'b0);
        wt(60);
        chk(sys_reset, 1'b1);
        // early service in window mode
        do_reset;
        wr(WWDT_CTRL_OFS, 32'h81);
        wt(100);
        wr(WWDT_SVC_OFS, 32'h55);
        wt(3);
        chk(sys_reset, 1'b1);
        // service inside the open window
        do_reset;
        wr(WWDT_CTRL_OFS, 32'h81);
        wt(12288 + 40);
        wr(WWDT_SVC_OFS, 32'h55);
        wr(WWDT_SVC_OFS, 32'h55);
        wr(WWDT_SVC_OFS, 32'haa);
        wt(3);
        chk(sys_reset, 1'b0);
        apb(1'b0, WWDT_STAT_OFS, 32'h0);
        chk(rd[23:0] < 24'd20, 1'b1);
        wr(WWDT_SVC_OFS, 32'h55);
        wt(3);
        chk(sys_reset, 1'b1);
        // undefined service byte
        do_reset;
        wr(WWDT_CTRL_OFS, 32'h1);
        v = 8'($random(seed));
        if (v == 8'h55 || v == 8'haa)
            v = 8'h01;
        wr(WWDT_SVC_OFS, {24'h0, v});
        wt(3);
        chk(sys_reset, 1'b1);
        // halt in background debug
        do_reset;
        wr(WWDT_CTRL_OFS, 32'h41);
        debug_active <= 1'b1;
        wt(3);
        chk(tick_halt, 1'b1);
        apb(1'b0, WWDT_STAT_OFS, 32'h0);
        s1 = rd;
        wt(20);
        rdc(WWDT_STAT_OFS, s1);
        debug_active <= 1'b0;
        wt(20);
        apb(1'b0, WWDT_STAT_OFS, 32'h0);
        chk(rd > s1, 1'b1);
        // oscillator ticks only, random pulses
        do_reset;
        wr(WWDT_CFG_OFS, 32'h1);
        wr(WWDT_CTRL_OFS, 32'h1);
        n_osc = 0;
        repeat (200) begin
            @(posedge ref_clk);
            v = 8'($random(seed));
            osc_tick <= v[0];
            irc_tick <= ~v[0];
            n_osc += v[0];
        end
        @(posedge ref_clk);
        osc_tick <= 1'b0;
        rdc(WWDT_STAT_OFS, 32'h0300_0000 + 32'(n_osc));
        // forced longest normal period
        do_reset;
        special_mode <= 1'b1;
        debug_active <= 1'b1;
        wr(WWDT_CTRL_OFS, 32'h81);
        wr(WWDT_SVC_OFS, 32'h55);
        wt(16384 + 100);
        chk(sys_reset, 1'b0);
        stop_test;
    end

endmodule
